// file: hw/core_pkg.sv
// Shared constants and carrier types for the register file, stack and interrupt core
package core_pkg;
    localparam int         REG_COUNT      = 32;
    localparam logic [4:0] PTR_X_LOW      = 5'h1a;
    localparam logic [4:0] PTR_Y_LOW      = 5'h1c;
    localparam logic [4:0] PTR_Z_LOW      = 5'h1e;
    localparam logic [15:0] IO_DS_BASE    = 16'h0020;
    localparam logic [5:0] SP_LOW_IO      = 6'h3d;
    localparam logic [5:0] SP_HIGH_IO     = 6'h3e;
    localparam logic [5:0] STATUS_IO      = 6'h3f;
    localparam logic [7:0] SP_LOW_RESET   = 8'h00;
    localparam logic [7:0] SP_HIGH_RESET  = 8'h00;
    localparam logic [7:0] STATUS_RESET   = 8'h00;
    localparam int         GIE_BIT        = 7;
    localparam logic [1:0] ENTRY_CYCLES   = 2'h3;
    localparam logic [1:0] RETURN_CYCLES  = 2'h3;
    localparam logic [14:0] VECTOR_STRIDE = 15'h0002;

    typedef enum logic [1:0] {
        SEL_X = 2'h0,
        SEL_Y = 2'h1,
        SEL_Z = 2'h2
    } ptr_sel_t;

    typedef enum logic [1:0] {
        MODE_DISP    = 2'h0,
        MODE_POSTINC = 2'h1,
        MODE_PREDEC  = 2'h2
    } ptr_mode_t;

    typedef enum logic [2:0] {
        STK_NONE  = 3'h0,
        STK_PUSH1 = 3'h1,
        STK_POP1  = 3'h2,
        STK_PUSH2 = 3'h3,
        STK_POP2  = 3'h4
    } stack_op_t;

    typedef struct packed {
        logic      go;
        ptr_sel_t  sel;
        ptr_mode_t mode;
        logic [5:0] disp;
    } ptr_req_t;

    typedef struct packed {
        logic       we;
        logic       wide;
        logic [4:0] addr;
        logic [15:0] data;
    } wb_req_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } ds_req_t;
endpackage

// file: hw/irq_priority.sv
// Priority pick of the lowest numbered active interrupt request
`timescale 1ns/1ps
module irq_priority #(
    parameter int N_IRQ = 8,
    parameter int IDX_W = 3
) (
    // Requests
    input  wire logic [N_IRQ-1:0] req,
    // Winner
    output logic                  any,
    output logic [IDX_W-1:0]      idx
);
    always_comb begin
        any = 1'b0;
        idx = '0;
        // Lowest index is lowest vector address, so it wins
        for (int i = N_IRQ - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = IDX_W'(i);
            end
        end
    end
endmodule

// file: hw/cpu_regfile_stack_interrupt_core.sv
// Working registers, stack pointer and interrupt entry/exit of the 8-bit core
//
// Overview of operation
// - 32 working registers occupy data addresses 0x00-0x1f
// - Registers 26-31 form three pointers, low byte first
// - Pointers do displacement, post-increment, pre-decrement
// - Ports: 8/8 read, 8-bit or 16-bit write
// - Push decrements, pop increments stack pointer by one
// - Call/entry subtract two, return adds two
// - Stack pointer bytes at I/O 0x3e/0x3d, reset zero
// - Core runs on undivided system clock
// - Two-operand read and write-back in one cycle
// - Service needs local and global enable set
// - Boot lock bits suppress interrupts by counter region
// - Lower vector wins; reset highest, then irq zero
// - Select bit and fuse move vectors to boot
// - Entry clears global enable; return sets it
// - Vectoring or writing one clears the flag
// - Flags stay pending until enabled or cleared
// - Level requests act only while condition present
// - One instruction runs after return before interrupts
// - Status register not saved or restored
// - Disable takes effect in its own cycle
// - Entry takes four cycles, waits instruction boundary
// - Return takes four cycles, pops two, sets enable
// - Instruction after enable runs before any interrupt
`timescale 1ns/1ps
module cpu_regfile_stack_interrupt_core
    import core_pkg::*;
#(
    parameter int N_IRQ = 8,
    parameter int IDX_W = 3
) (
    // Clock and reset
    input  wire logic                  clk, // Undivided core clock drives every flop
    input  wire logic                  rst,
    // Operand reads and write-back
    input  wire logic [4:0]            rd_a_addr,
    input  wire logic [4:0]            rd_b_addr,
    output logic [7:0]                 rd_a_data,
    output logic [7:0]                 rd_b_data,
    output logic [15:0]                rd_wide_data,
    input  wire core_pkg::wb_req_t     wb,
    // Pointer addressing
    input  wire core_pkg::ptr_req_t    ptr,
    output logic [15:0]                ptr_addr,
    // Data-space access
    input  wire core_pkg::ds_req_t     ds,
    output logic [7:0]                 ds_rdata,
    output logic                       ds_hit,
    // Stack control and memory
    input  wire core_pkg::stack_op_t   stack_op,
    output logic [15:0]                stack_top_pointer,
    output logic                       stack_wr,
    output logic                       stack_rd,
    output logic [15:0]                stack_addr,
    output logic [7:0]                 stack_wdata,
    input  wire logic [7:0]            stack_rdata,
    // Status register
    input  wire logic                  alu_flags_we,
    input  wire logic [6:0]            alu_flags,
    input  wire logic                  sei_go,
    input  wire logic                  cli_go,
    output logic [7:0]                 status_register,
    // Instruction flow
    input  wire logic                  insn_done,
    input  wire logic                  return_from_irq_go,
    input  wire logic [14:0]           pc,
    output logic                       busy,
    output logic                       vector_valid,
    output logic [14:0]                vector_addr,
    output logic                       pc_restore_valid,
    output logic [14:0]                pc_restore,
    output logic [14:0]                reset_vector,
    // Interrupt sources
    input  wire logic [N_IRQ-1:0]      irq_flag_set,
    input  wire logic [N_IRQ-1:0]      irq_flag_clear,
    input  wire logic [N_IRQ-1:0]      irq_is_level,
    input  wire logic [N_IRQ-1:0]      irq_level,
    input  wire logic [N_IRQ-1:0]      irq_enable,
    output logic [N_IRQ-1:0]           irq_flags,
    // Boot section controls
    input  wire logic                  vector_table_select,
    input  wire logic                  reset_vector_relocate_fuse,
    input  wire logic                  boot_lock_bit_a,
    input  wire logic                  boot_lock_bit_b,
    input  wire logic [14:0]           boot_start
);
    import core_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ENTRY  = 3'b010,
        ST_RETURN = 3'b100
    } irq_state_t;

    function automatic logic io_hit(input logic [15:0] a, input logic [5:0] io);
        return a == (IO_DS_BASE + {10'h000, io});
    endfunction

    function automatic logic [4:0] ptr_base(input ptr_sel_t s);
        case (s)
            SEL_X:   return PTR_X_LOW;
            SEL_Y:   return PTR_Y_LOW;
            default: return PTR_Z_LOW;
        endcase
    endfunction

    logic [7:0]       regs [REG_COUNT];
    irq_state_t       state;
    logic [1:0]       step;
    logic             holdoff;
    logic [IDX_W-1:0] taken_idx;
    logic [7:0]       pop_high;
    logic [15:0]      sp;
    logic             pick_any;
    logic [IDX_W-1:0] pick_idx;
    logic [N_IRQ-1:0] active;
    logic             suppress;
    logic             gie_now;
    logic             accept;
    logic [4:0]       pb;
    logic [15:0]      ptr_val;
    logic [15:0]      next_ptr_addr;
    logic [15:0]      next_ptr_val;
    logic             ds_reg;

    assign sp = {stack_top_pointer};

    // Reads straight from the flop array, so a write lands before the next read
    assign rd_a_data    = regs[rd_a_addr];
    assign rd_b_data    = regs[rd_b_addr];
    assign rd_wide_data = {regs[rd_a_addr | 5'h01], regs[rd_a_addr & 5'h1e]};

    assign pb      = ptr_base(ptr.sel);
    assign ptr_val = {regs[pb | 5'h01], regs[pb]};

    always_comb begin
        next_ptr_addr = ptr_val;
        next_ptr_val  = ptr_val;
        case (ptr.mode)
            MODE_DISP:    next_ptr_addr = ptr_val + {10'h000, ptr.disp};
            MODE_POSTINC: next_ptr_val  = ptr_val + 16'h0001;
            MODE_PREDEC: begin
                next_ptr_val  = ptr_val - 16'h0001;
                next_ptr_addr = ptr_val - 16'h0001;
            end
            default:      next_ptr_addr = ptr_val;
        endcase
    end

    assign ds_reg = ds.addr < 16'(REG_COUNT);

    // Register file: pointer update first, write-back, then data space wins last
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= 8'h00;
            end
        end else begin
            if (ptr.go && ptr.mode != MODE_DISP) begin
                regs[pb]        <= next_ptr_val[7:0];
                regs[pb | 5'h01] <= next_ptr_val[15:8];
            end
            if (wb.we) begin
                regs[wb.addr] <= wb.data[7:0];
                if (wb.wide) begin
                    regs[wb.addr | 5'h01] <= wb.data[15:8];
                end
            end
            if (ds.wr && ds_reg) begin
                regs[ds.addr[4:0]] <= ds.wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ptr_addr <= 16'h0000;
        end else if (ptr.go) begin
            ptr_addr <= next_ptr_addr;
        end
    end

    // Data-space read answers one cycle later
    always_ff @(posedge clk) begin
        if (rst) begin
            ds_rdata <= 8'h00;
            ds_hit   <= 1'b0;
        end else begin
            ds_hit   <= ds.rd && (ds_reg || io_hit(ds.addr, SP_LOW_IO) || io_hit(ds.addr, SP_HIGH_IO)
                        || io_hit(ds.addr, STATUS_IO));
            ds_rdata <= 8'h00;
            if (ds.rd) begin
                if (ds_reg) begin
                    ds_rdata <= regs[ds.addr[4:0]];
                end else if (io_hit(ds.addr, SP_LOW_IO)) begin
                    ds_rdata <= sp[7:0];
                end else if (io_hit(ds.addr, SP_HIGH_IO)) begin
                    ds_rdata <= sp[15:8];
                end else if (io_hit(ds.addr, STATUS_IO)) begin
                    ds_rdata <= status_register;
                end
            end
        end
    end

    // Stack pointer; software writes take priority over implicit updates
    always_ff @(posedge clk) begin
        if (rst) begin
            stack_top_pointer <= {SP_HIGH_RESET, SP_LOW_RESET};
        end else if (ds.wr && io_hit(ds.addr, SP_LOW_IO)) begin
            stack_top_pointer[7:0] <= ds.wdata;
        end else if (ds.wr && io_hit(ds.addr, SP_HIGH_IO)) begin
            stack_top_pointer[15:8] <= ds.wdata;
        end else if (state == ST_ENTRY && step < 2'h2) begin
            stack_top_pointer <= sp - 16'h0001;
        end else if (state == ST_RETURN && step < 2'h2) begin
            stack_top_pointer <= sp + 16'h0001;
        end else if (state == ST_IDLE) begin
            case (stack_op)
                STK_PUSH1: stack_top_pointer <= sp - 16'h0001;
                STK_POP1:  stack_top_pointer <= sp + 16'h0001;
                STK_PUSH2: stack_top_pointer <= sp - 16'h0002;
                STK_POP2:  stack_top_pointer <= sp + 16'h0002;
                default:   stack_top_pointer <= sp;
            endcase
        end
    end

    // Interrupt request gathering
    always_comb begin
        for (int i = 0; i < N_IRQ; i++) begin
            // Level sources request only while the condition holds
            active[i] = irq_enable[i] && (irq_is_level[i] ? irq_level[i] : irq_flags[i]);
        end
    end

    irq_priority #(
        .N_IRQ (N_IRQ),
        .IDX_W (IDX_W)
    ) u_pick (
        .req (active),
        .any (pick_any),
        .idx (pick_idx)
    );

    // Application code may not be interrupted into a locked boot table, and vice versa
    assign suppress = (boot_lock_bit_a && vector_table_select && pc < boot_start)
                   || (boot_lock_bit_b && !vector_table_select && pc >= boot_start);
    assign gie_now  = status_register[GIE_BIT] && !cli_go;
    assign accept   = state == ST_IDLE && insn_done && pick_any && gie_now && !holdoff
                   && !suppress && !return_from_irq_go;

    // Flags: hardware set beats any clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_flags <= '0;
        end else begin
            for (int i = 0; i < N_IRQ; i++) begin
                if (irq_flag_set[i] && !irq_is_level[i]) begin
                    irq_flags[i] <= 1'b1;
                end else if (irq_flag_clear[i] || (accept && pick_idx == IDX_W'(i))) begin
                    irq_flags[i] <= 1'b0;
                end
            end
        end
    end

    // Status: only the enable bit is touched by entry and return
    always_ff @(posedge clk) begin
        if (rst) begin
            status_register <= STATUS_RESET;
        end else begin
            if (ds.wr && io_hit(ds.addr, STATUS_IO)) begin
                status_register <= ds.wdata;
            end else if (alu_flags_we) begin
                status_register[6:0] <= alu_flags;
            end
            if (cli_go || accept) begin
                status_register[GIE_BIT] <= 1'b0;
            end else if (sei_go || (state == ST_RETURN && step == RETURN_CYCLES)) begin
                status_register[GIE_BIT] <= 1'b1;
            end
        end
    end

    // One instruction must complete after return or enable before the next entry
    always_ff @(posedge clk) begin
        if (rst) begin
            holdoff <= 1'b0;
        end else if (sei_go || (state == ST_RETURN && step == RETURN_CYCLES)) begin
            holdoff <= 1'b1;
        end else if (insn_done && state == ST_IDLE) begin
            holdoff <= 1'b0;
        end
    end

    // Entry and return sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state     <= ST_IDLE;
            step      <= 2'h0;
            taken_idx <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    step <= 2'h0;
                    if (accept) begin
                        state     <= ST_ENTRY;
                        taken_idx <= pick_idx;
                    end else if (return_from_irq_go) begin
                        state <= ST_RETURN;
                    end
                end
                ST_ENTRY: begin
                    step <= step + 2'h1;
                    if (step == ENTRY_CYCLES) begin
                        state <= ST_IDLE;
                    end
                end
                ST_RETURN: begin
                    step <= step + 2'h1;
                    if (step == RETURN_CYCLES) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Stack memory strobes; low byte of the counter goes to the higher address
    always_ff @(posedge clk) begin
        if (rst) begin
            stack_wr    <= 1'b0;
            stack_rd    <= 1'b0;
            stack_addr  <= 16'h0000;
            stack_wdata <= 8'h00;
        end else begin
            stack_wr <= (state == ST_IDLE && accept) || (state == ST_ENTRY && step == 2'h0);
            stack_rd <= (state == ST_IDLE && return_from_irq_go && !accept) || (state == ST_RETURN && step == 2'h0);
            if (state == ST_IDLE && accept) begin
                stack_addr  <= sp;
                stack_wdata <= pc[7:0];
            end else if (state == ST_ENTRY && step == 2'h0) begin
                // Pointer only moves on this edge, so address the byte below it
                stack_addr  <= sp - 16'h0001;
                stack_wdata <= {1'b0, pc[14:8]};
            end else if (state == ST_IDLE && return_from_irq_go) begin
                stack_addr <= sp + 16'h0001;
            end else if (state == ST_RETURN && step == 2'h0) begin
                stack_addr <= sp + 16'h0002;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            busy             <= 1'b0;
            vector_valid     <= 1'b0;
            vector_addr      <= 15'h0000;
            pc_restore_valid <= 1'b0;
            pc_restore       <= 15'h0000;
            pop_high         <= 8'h00;
            reset_vector     <= 15'h0000;
        end else begin
            busy <= (state == ST_IDLE && (accept || return_from_irq_go))
                 || (state != ST_IDLE && step != 2'h3);
            reset_vector <= reset_vector_relocate_fuse ? boot_start : 15'h0000;
            vector_valid <= state == ST_ENTRY && step == 2'h2;
            if (state == ST_ENTRY && step == 2'h2) begin
                // Vector slot 0 is reset, so sources start at slot 1
                vector_addr <= (vector_table_select ? boot_start : 15'h0000)
                             + VECTOR_STRIDE * (15'(taken_idx) + 15'h0001);
            end
            if (state == ST_RETURN && step == 2'h1) begin
                pop_high <= stack_rdata;
            end
            pc_restore_valid <= state == ST_RETURN && step == 2'h2;
            if (state == ST_RETURN && step == 2'h2) begin
                // Stored high byte carries a spare top bit, dropped here
                pc_restore <= {pop_high[6:0], stack_rdata};
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence entry_seq;
        accept ##1 (state == ST_ENTRY) [*4];
    endsequence

    sequence return_seq;
        (state == ST_IDLE && return_from_irq_go && !accept) ##1 (state == ST_RETURN) [*4];
    endsequence

    entry_four_cycles_a: assert property (accept |-> ##1 (state == ST_ENTRY) [*4] ##1 state == ST_IDLE)
        else $error("entry did not last four cycles");
    entry_sp_two_a: assert property (entry_seq |-> sp == $past(sp, 4) - 16'h0002)
        else $error("entry did not lower stack pointer by two");
    return_sp_two_a: assert property (return_seq |-> sp == $past(sp, 4) + 16'h0002)
        else $error("return did not raise stack pointer by two");
    return_sets_gie_a: assert property (return_seq |=> status_register[GIE_BIT])
        else $error("return left global enable clear");
    entry_clears_gie_a: assert property (accept |=> !status_register[GIE_BIT])
        else $error("entry left global enable set");
    cli_blocks_entry_a: assert property (cli_go |-> !accept)
        else $error("interrupt taken with disable");
    sei_holdoff_a: assert property (sei_go |=> !accept)
        else $error("interrupt taken right after enable");
    push_one_a: assert property (state == ST_IDLE && stack_op == STK_PUSH1 && !ds.wr
                                 |=> sp == $past(sp) - 16'h0001)
        else $error("push did not lower stack pointer by one");
    flag_set_wins_a: assert property (irq_flag_set[0] && !irq_is_level[0] |=> irq_flags[0])
        else $error("flag set lost");
    accept_needs_enable_a: assert property (accept |-> irq_enable[pick_idx] && status_register[GIE_BIT])
        else $error("interrupt taken without enables");
endmodule

// file: dv/stack_mem_model.sv
// Behavioural data memory that holds the bytes the core pushes and pops
`timescale 1ns/1ps
module stack_mem_model (
    // Clock
    input  wire logic        clk,
    // Stack port of the core
    input  wire logic        stack_wr,
    input  wire logic        stack_rd,
    input  wire logic [15:0] stack_addr,
    input  wire logic [7:0]  stack_wdata,
    output logic [7:0]       stack_rdata
);
    logic [7:0] mem [0:511];
    logic [7:0] rdata_q = 8'h5a;

    // Saved counter bytes are kept whole; dropping the unused top bit is the reader's job
    always @(posedge clk) begin
        if (stack_wr) begin
            mem[stack_addr[8:0]] <= stack_wdata;
        end
        // Outside a read the line toggles, so a late sample never sees stale data
        rdata_q <= stack_rd ? mem[stack_addr[8:0]] : ~rdata_q;
    end
    assign stack_rdata = rdata_q;
endmodule

// file: dv/cpu_regfile_stack_interrupt_core_bench.sv
// Self-checking bench for the register file, stack pointer and interrupt core
`timescale 1ns/1ps
module cpu_regfile_stack_interrupt_core_bench;
    import core_pkg::*;
    logic clk, rst, insn_done, return_from_irq_go, sei_go, cli_go, alu_flags_we, stack_wr, stack_rd, ds_hit, busy;
    logic vector_valid, pc_restore_valid, vector_table_select, reset_vector_relocate_fuse;
    logic boot_lock_bit_a, boot_lock_bit_b;
    logic [4:0] rd_a_addr, rd_b_addr;
    logic [6:0] alu_flags;
    logic [7:0] rd_a_data, rd_b_data, ds_rdata, stack_wdata, stack_rdata, status_register, irq_flags;
    logic [7:0] irq_flag_set, irq_flag_clear, irq_is_level, irq_level, irq_enable;
    logic [14:0] pc, vector_addr, pc_restore, reset_vector, boot_start;
    logic [15:0] rd_wide_data, ptr_addr, stack_top_pointer, stack_addr;
    wb_req_t   wb;
    ptr_req_t  ptr;
    ds_req_t   ds;
    stack_op_t stack_op;
    stack_op_t ops [4] = '{STK_PUSH1, STK_POP1, STK_PUSH2, STK_POP2};
    logic [15:0] sp_exp [4] = '{16'h00ff, 16'h0100, 16'h00fe, 16'h0100};
    int mismatches = 0, tests_run = 0, cycles = 0, n;

    cpu_regfile_stack_interrupt_core u_cpu_regfile_stack_interrupt_core (.*);
    stack_mem_model u_stack_mem_model (.*);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic ds_acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) ds <= '{w, !w, a, d};
        @(posedge clk) ds <= '0;
        @(negedge clk);
    endtask
    task automatic wb_put(input logic wide, input logic [4:0] a, input logic [15:0] d);
        @(posedge clk) wb <= '{1'b1, wide, a, d};
        @(posedge clk) wb <= '0;
        @(negedge clk);
    endtask
    task automatic ptr_go(input ptr_sel_t s, input ptr_mode_t m, input logic [5:0] d);
        @(posedge clk) ptr <= '{1'b1, s, m, d};
        @(posedge clk) ptr <= '0;
        @(negedge clk);
    endtask
    task automatic rd_sel(input logic [4:0] a, input logic [4:0] b);
        @(posedge clk) rd_a_addr <= a;
        rd_b_addr <= b;
        @(negedge clk);
    endtask
    // Bits: instruction boundary, return, enable, disable
    task automatic pulse(input logic [3:0] v);
        @(posedge clk) {insn_done, return_from_irq_go, sei_go, cli_go} <= v;
        @(posedge clk) {insn_done, return_from_irq_go, sei_go, cli_go} <= '0;
    endtask
    task automatic wait_for(input logic ret, output int cnt);
        cnt = 0;
        while (cnt < 12 && (ret ? pc_restore_valid : vector_valid) !== 1'b1) begin
            @(negedge clk);
            cnt++;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        rst = 1'b1;
        {insn_done, return_from_irq_go, sei_go, cli_go, alu_flags_we, alu_flags} = '0;
        {vector_table_select, reset_vector_relocate_fuse, boot_lock_bit_a, boot_lock_bit_b} = '0;
        {irq_flag_set, irq_flag_clear, irq_is_level, irq_level, irq_enable} = '0;
        {rd_a_addr, rd_b_addr, boot_start} = '0;
        {wb, ptr, ds} = '0;
        stack_op = STK_NONE;
        pc = 15'h1234;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        ds_acc(1'b0, 16'h005d, 8'h00);
        check(ds_rdata, 16'h0000);
        check(ds_hit, 16'h0001);
        ds_acc(1'b0, 16'h005e, 8'h00);
        check(ds_rdata, 16'h0000);
        ds_acc(1'b0, 16'h0300, 8'h00);
        check(ds_hit, 16'h0000);
        // Stack placed well above the I/O area before any call or interrupt
        ds_acc(1'b1, 16'h005e, 8'h01);
        ds_acc(1'b1, 16'h005d, 8'h00);
        check(stack_top_pointer, 16'h0100);
        ds_acc(1'b1, 16'h0003, 8'ha5);
        rd_sel(5'd3, 5'd0);
        check(rd_a_data, 16'h00a5);
        wb_put(1'b0, 5'd5, 16'h003c);
        ds_acc(1'b0, 16'h0005, 8'h00);
        check(ds_rdata, 16'h003c);
        wb_put(1'b1, 5'd30, 16'h0100);
        ds_acc(1'b0, 16'h001f, 8'h00);
        check(ds_rdata, 16'h0001);
        ptr_go(SEL_Z, MODE_POSTINC, 6'h00);
        check(ptr_addr, 16'h0100);
        rd_sel(5'd30, 5'd5);
        check(rd_wide_data, 16'h0101);
        check(rd_b_data, 16'h003c);
        ptr_go(SEL_Z, MODE_PREDEC, 6'h00);
        check(ptr_addr, 16'h0100);
        ptr_go(SEL_Z, MODE_DISP, 6'h05);
        check(ptr_addr, 16'h0105);
        check(rd_wide_data, 16'h0100);
        foreach (ops[i]) begin
            @(posedge clk) stack_op <= ops[i];
            @(posedge clk) stack_op <= STK_NONE;
            @(negedge clk);
            check(stack_top_pointer, sp_exp[i]);
        end
        // Flag 2 raised while disabled, level source 0 drops before it is enabled
        @(posedge clk) {irq_flag_set, irq_is_level, irq_level} <= {8'h04, 8'h01, 8'h01};
        {alu_flags_we, alu_flags} <= {1'b1, 7'h2a};
        @(posedge clk) {irq_flag_set, irq_level, alu_flags_we} <= '0;
        @(negedge clk);
        check(irq_flags, 16'h0004);
        @(posedge clk) irq_enable <= 8'h07;
        pulse(4'h2);
        pulse(4'h8);
        wait_for(1'b0, n);
        check(n, 16'd12);
        pulse(4'h8);
        wait_for(1'b0, n);
        check(n >= 4 && n < 12, 16'h0001);
        check(vector_addr, 16'h0006);
        check(stack_top_pointer, 16'h00fe);
        check(status_register, 16'h002a);
        check(irq_flags, 16'h0000);
        pulse(4'h4);
        wait_for(1'b1, n);
        check(n < 12, 16'h0001);
        check(pc_restore, 16'h1234);
        // Enable is set on the last return edge, one cycle after the restored counter shows
        @(negedge clk);
        check(status_register[7], 16'h0001);
        check(stack_top_pointer, 16'h0100);
        @(posedge clk) irq_flag_set <= 8'h02;
        @(posedge clk) irq_flag_set <= '0;
        pulse(4'h8);
        wait_for(1'b0, n);
        check(n, 16'd12);
        // Disable lands on the same boundary that would otherwise accept
        pulse(4'h9);
        wait_for(1'b0, n);
        check(n, 16'd12);
        check(status_register[7], 16'h0000);
        check(irq_flags, 16'h0002);
        @(posedge clk) irq_flag_clear <= 8'h02;
        @(posedge clk) irq_flag_clear <= '0;
        @(negedge clk);
        check(irq_flags, 16'h0000);
        // Fuse moves the reset vector; lock bit b masks sources while running from boot
        @(posedge clk) {reset_vector_relocate_fuse, boot_lock_bit_b} <= 2'b11;
        {boot_start, pc, irq_flag_set} <= {15'h7000, 15'h7100, 8'h02};
        @(posedge clk) irq_flag_set <= '0;
        pulse(4'h2);
        pulse(4'h8);
        pulse(4'h8);
        wait_for(1'b0, n);
        check(n, 16'd12);
        check(reset_vector, 16'h7000);
        @(posedge clk) {vector_table_select, boot_lock_bit_b} <= 2'b10;
        pulse(4'h8);
        wait_for(1'b0, n);
        check(vector_addr, 16'h7004);
        check(busy, 16'h0001);
        @(negedge clk);
        check(busy, 16'h0000);
        results();
    end
endmodule
